// *** htvu_trap_unit.sv ***
// htvu_trap_unit: trap detection, flags, service priority and vector address forming
// assumes trap conditions are one-cycle pulses from core_clk logic, and service end is signalled by the pipeline
`timescale 1ns/1ns
`default_nettype none
module htvu_trap_unit (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [htvu_pkg::TRAP_COUNT-1:0] trapCond,
    input wire logic [htvu_pkg::TRAP_COUNT-1:0] flagClear,
    input wire logic serviceDone,
    input wire logic [htvu_pkg::SEG_W-1:0] vectorSegment,
    input wire logic [htvu_pkg::SPC_W-1:0] vectorSpacing,
    input wire logic nodeReq,
    input wire logic [htvu_pkg::TNUM_W-1:0] nodeTrapNum,
    output htvu_pkg::htvu_redirect_t redirect,
    output logic [htvu_pkg::TRAP_COUNT-1:0] trapFlags,
    output logic [htvu_pkg::SEG_W+htvu_pkg::OFS_W-1:0] nodeVector,
    output logic intBlock,
    output logic [1:0] activePrio
);
    import htvu_pkg::*;

    htvu_state_t state, next_state;
    logic [TRAP_COUNT-1:0] next_trapFlags;
    htvu_redirect_t next_redirect;
    logic [SEG_W+OFS_W-1:0] next_nodeVector;
    logic [TRAP_COUNT-1:0] pend, next_pend;
    logic [1:0] next_activePrio;
    logic next_intBlock;

    // offset of a trap number under the current spacing
    function automatic logic [OFS_W-1:0] vecOfs(input logic [TNUM_W-1:0] tn, input logic [SPC_W-1:0] spc);
        logic [OFS_W-1:0] base;
        base = OFS_W'(tn) << BASE_SHIFT;
        vecOfs = base << spc;
    endfunction : vecOfs

    function automatic logic [SEG_W+OFS_W-1:0] vecAddr(input logic [TNUM_W-1:0] tn,
        input logic [SEG_W-1:0] seg, input logic [SPC_W-1:0] spc);
        vecAddr = {seg, vecOfs(tn, spc)};
    endfunction : vecAddr

    // service state, pending causes, service priority and redirect choice
    always_comb begin
        logic [TRAP_COUNT-1:0] allPend;
        logic [TRAP_COUNT-1:0] aMask;
        allPend = pend | trapCond;
        aMask = TRAP_COUNT'((1 << CLASS_A_COUNT) - 1);
        next_pend = allPend;
        next_state = state;
        next_redirect = '0;
        if (serviceDone && state != HTVU_IDLE) begin
            next_state = HTVU_IDLE;
        end
        // class A outranks an active class B service; same or lower waits
        if ((allPend & aMask) != '0 && (state != HTVU_SERVE_A || serviceDone)) begin
            next_state = HTVU_SERVE_A;
            next_redirect.valid = 1'b1;
            if (allPend[FLAG_SR0]) begin
                next_redirect.trapNum = TNUM_SR0;
                next_pend[FLAG_SR0] = 1'b0;
            end else if (allPend[FLAG_STACK_OVERFLOW_FLAG]) begin
                next_redirect.trapNum = TNUM_STACK_OVERFLOW_FLAG;
                next_pend[FLAG_STACK_OVERFLOW_FLAG] = 1'b0;
            end else if (allPend[FLAG_STACK_UNDERFLOW_FLAG]) begin
                next_redirect.trapNum = TNUM_STACK_UNDERFLOW_FLAG;
                next_pend[FLAG_STACK_UNDERFLOW_FLAG] = 1'b0;
            end else begin
                next_redirect.trapNum = TNUM_SOFTWARE_BREAK_FLAG;
                next_pend[FLAG_SOFTWARE_BREAK_FLAG] = 1'b0;
            end
        end else if ((allPend & ~aMask) != '0 && (state == HTVU_IDLE || serviceDone)) begin
            next_state = HTVU_SERVE_B;
            next_redirect.valid = 1'b1;
            next_redirect.trapNum = TNUM_CLASS_B;
            next_pend = allPend & aMask;
        end
        next_redirect.addr = vecAddr(next_redirect.trapNum, vectorSegment, vectorSpacing);
        case (next_state)
            HTVU_SERVE_A: next_activePrio = PRIO_A;
            HTVU_SERVE_B: next_activePrio = PRIO_B;
            default: next_activePrio = PRIO_NONE;
        endcase
        next_intBlock = (next_state != HTVU_IDLE);
    end

    // service state registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= HTVU_IDLE;
            pend <= FLAGS_RESET;
            redirect <= '0;
            intBlock <= 1'b0;
            activePrio <= PRIO_NONE;
        end else begin
            state <= next_state;
            pend <= next_pend;
            redirect <= next_redirect;
            intBlock <= next_intBlock;
            activePrio <= next_activePrio;
        end
    end

    // sticky trap flags: a new cause in the clear cycle wins,
    // so software never loses an event that lands on its own clear
    always_comb begin
        next_trapFlags = (trapFlags & ~flagClear) | trapCond;
    end

    // flag registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            trapFlags <= FLAGS_RESET;
        end else begin
            trapFlags <= next_trapFlags;
        end
    end

    // node vector lookup: holds the last answer between requests,
    // uses the segment and spacing seen at the request edge
    always_comb begin
        next_nodeVector = nodeVector;
        if (nodeReq) begin
            next_nodeVector = vecAddr(nodeTrapNum, vectorSegment, vectorSpacing);
        end
    end

    // node vector register
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            nodeVector <= '0;
        end else begin
            nodeVector <= next_nodeVector;
        end
    end

    // checks
    flag_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        trapCond[FLAG_MEMORY_ACCESS_ERROR_FLAG] |=> trapFlags[FLAG_MEMORY_ACCESS_ERROR_FLAG]) else $error("trap flag not set");
    trap_react_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (trapCond[FLAG_STACK_OVERFLOW_FLAG] && state == HTVU_IDLE) |=> redirect.valid) else $error("no redirect");
    class_b_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (redirect.valid && activePrio == PRIO_B) |-> redirect.trapNum == TNUM_CLASS_B) else $error("bad B vector");
    a_vector_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (redirect.valid && redirect.trapNum == TNUM_STACK_UNDERFLOW_FLAG && $past(vectorSpacing) == SPC_DEFAULT
         && $past(vectorSegment) == SEG_RESET) |-> redirect.addr == 24'h00_0018) else $error("bad A vector");
    block_int_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        redirect.valid |-> (intBlock && activePrio != PRIO_NONE)) else $error("interrupt block wrong");
    no_preempt_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state == HTVU_SERVE_A && !serviceDone) |=> !redirect.valid) else $error("A service preempted");
    node_vec_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (nodeReq && nodeTrapNum == 7'h6F && vectorSpacing == SPC_DEFAULT)
        |=> nodeVector[OFS_W-1:0] == 16'h01BC) else $error("bad node vector");
    seg_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        nodeReq |=> nodeVector[SEG_W+OFS_W-1:OFS_W] == $past(vectorSegment)) else $error("bad segment");
    scale_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (nodeReq && vectorSpacing == 2'h1) |=> nodeVector[OFS_W-1:0] == 16'(($past(nodeTrapNum)) * 8))
        else $error("bad spacing scale");
    serve_b_c: cover property (@(posedge core_clk) disable iff (!arst_n) state == HTVU_SERVE_B);
    a_over_b_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        state == HTVU_SERVE_B ##1 state == HTVU_SERVE_A);
    node_c: cover property (@(posedge core_clk) disable iff (!arst_n) nodeReq && vectorSpacing != SPC_DEFAULT);
    b_wait_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        state == HTVU_SERVE_A && pend[FLAG_UNDEFINED_OPCODE_FLAG]);
    b_merge_c: cover property (@(posedge core_clk) disable iff (!arst_n)
        trapCond[FLAG_SR1] && trapCond[FLAG_MEMORY_ACCESS_ERROR_FLAG] && state == HTVU_IDLE);

    // flag behaviour beyond the first set
    flag_sticky_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (trapFlags[FLAG_SR1] && !flagClear[FLAG_SR1]) |=> trapFlags[FLAG_SR1]) else $error("flag lost");
    flag_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (flagClear[FLAG_UNDEFINED_OPCODE_FLAG] && !trapCond[FLAG_UNDEFINED_OPCODE_FLAG]) |=> !trapFlags[FLAG_UNDEFINED_OPCODE_FLAG])
        else $error("flag not cleared");
    set_wins_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (trapCond[FLAG_SR0] && flagClear[FLAG_SR0]) |=> trapFlags[FLAG_SR0]) else $error("clear beat set");

    // class A order: the highest pending cause is taken first
    sr0_first_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (trapCond[FLAG_SR0] && state != HTVU_SERVE_A)
        |=> (redirect.valid && redirect.trapNum == TNUM_SR0)) else $error("system request not first");
    stack_overflow_flag_next_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (trapCond[FLAG_STACK_OVERFLOW_FLAG] && !trapCond[FLAG_SR0] && !pend[FLAG_SR0] && state == HTVU_IDLE)
        |=> redirect.trapNum == TNUM_STACK_OVERFLOW_FLAG) else $error("overflow vector wrong");

    // class B merge: one shared redirect empties every waiting B cause
    b_drain_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (redirect.valid && redirect.trapNum == TNUM_CLASS_B) |-> pend[TRAP_COUNT-1:CLASS_A_COUNT] == '0)
        else $error("class B left pending");

    // segment of every redirect is the one seen at the edge that issues it
    seg_redirect_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        redirect.valid |-> redirect.addr[SEG_W+OFS_W-1:OFS_W] == $past(vectorSegment))
        else $error("redirect segment wrong");

    // priority level follows the class of the redirect
    prio_track_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (redirect.valid && redirect.trapNum != TNUM_CLASS_B) |-> activePrio == PRIO_A)
        else $error("class A priority wrong");

    // the block stands for the whole service and drops with its end if no cause is pending or arriving
    block_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (intBlock && !serviceDone) |=> intBlock) else $error("block dropped early");
    block_end_a: assert property (@(posedge core_clk) disable iff (!arst_n)
        (state != HTVU_IDLE && serviceDone && pend == '0 && trapCond == '0) |=> !intBlock)
        else $error("block held after return");
endmodule : htvu_trap_unit
`default_nettype wire

// *** htvu_pkg.sv ***
// htvu_pkg: constants and carrier types for the hardware trap vector unit
// assumes a 16-bit word machine with a 24-bit address of segment plus 16-bit offset
package htvu_pkg;
    localparam int TRAP_COUNT = 9;
    localparam int TNUM_W = 7;
    localparam int OFS_W = 16;
    localparam int SEG_W = 8;
    localparam int SPC_W = 2;
    // flag bit positions
    localparam int FLAG_SR0 = 0;
    localparam int FLAG_STACK_OVERFLOW_FLAG = 1;
    localparam int FLAG_STACK_UNDERFLOW_FLAG = 2;
    localparam int FLAG_SOFTWARE_BREAK_FLAG = 3;
    localparam int FLAG_SR1 = 4;
    localparam int FLAG_UNDEFINED_OPCODE_FLAG = 5;
    localparam int FLAG_MEMORY_ACCESS_ERROR_FLAG = 6;
    localparam int FLAG_PROTECTED_INSTRUCTION_FAULT_FLAG = 7;
    localparam int FLAG_ILLEGAL_WORD_OPERAND_FLAG = 8;
    localparam int CLASS_A_COUNT = 4;
    // trap numbers
    localparam logic [TNUM_W-1:0] TNUM_SR0 = 7'h02;
    localparam logic [TNUM_W-1:0] TNUM_STACK_OVERFLOW_FLAG = 7'h04;
    localparam logic [TNUM_W-1:0] TNUM_STACK_UNDERFLOW_FLAG = 7'h06;
    localparam logic [TNUM_W-1:0] TNUM_SOFTWARE_BREAK_FLAG = 7'h08;
    localparam logic [TNUM_W-1:0] TNUM_CLASS_B = 7'h0A;
    // default spacing code: 4 bytes per vector, shift of two
    localparam logic [SPC_W-1:0] SPC_DEFAULT = 2'h0;
    localparam int BASE_SHIFT = 2;
    // priority levels of trap services, higher wins
    localparam logic [1:0] PRIO_NONE = 2'h0;
    localparam logic [1:0] PRIO_B = 2'h1;
    localparam logic [1:0] PRIO_A = 2'h2;
    localparam logic [SEG_W-1:0] SEG_RESET = 8'h00;
    localparam logic [TRAP_COUNT-1:0] FLAGS_RESET = 9'h000;

    typedef enum logic [1:0] {
        HTVU_IDLE = 2'b00,
        HTVU_SERVE_B = 2'b01,
        HTVU_SERVE_A = 2'b11
    } htvu_state_t;

    // redirect request towards the fetch pipeline
    typedef struct packed {
        logic valid;
        logic [TNUM_W-1:0] trapNum;
        logic [SEG_W+OFS_W-1:0] addr;
    } htvu_redirect_t;
endpackage : htvu_pkg

// *** htvu_pipe_model.sv ***
// htvu_pipe_model: behavioural fetch pipeline that returns from each trap service
// assumes redirect and intBlock come from core_clk logic of the trap unit
`timescale 1ns/1ns
`default_nettype none
module htvu_pipe_model (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire htvu_pkg::htvu_redirect_t redirect,
    input wire logic intBlock,
    input wire logic [7:0] svcDelay,
    output logic serviceDone
);
    import htvu_pkg::*;
    logic [7:0] count;
    // service body runs svcDelay cycles from each branch, then one return pulse
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= 8'h00;
            serviceDone <= 1'b0;
        end else begin
            serviceDone <= 1'b0;
            if (redirect.valid) begin
                count <= 8'h00;
            end else if (intBlock && !serviceDone && count >= svcDelay) begin
                serviceDone <= 1'b1;
                count <= 8'h00;
            end else if (intBlock && !serviceDone) begin
                count <= count + 8'h01;
            end
        end
    end
endmodule : htvu_pipe_model
`default_nettype wire

// *** testbench.sv ***
// testbench: self-checking bench for htvu_trap_unit beside a pipeline model
// assumes redirect, flags and node vector answer one cycle after the request edge
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import htvu_pkg::*;
    logic core_clk = 1'b0, arst_n = 1'b0, nodeReq = 1'b0, serviceDone, intBlock;
    logic [TRAP_COUNT-1:0] trapCond = '0, flagClear = '0, trapFlags;
    logic [SEG_W-1:0] vectorSegment = '0;
    logic [SPC_W-1:0] vectorSpacing = '0;
    logic [TNUM_W-1:0] nodeTrapNum = '0, tn;
    logic [SEG_W+OFS_W-1:0] nodeVector;
    logic [1:0] activePrio;
    logic [7:0] svcDelay = 8'h03;
    logic [31:0] rnd = 32'h0000_4b6d;
    htvu_redirect_t redirect;
    int err_count = 0, check_count = 0;
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    htvu_trap_unit uut (.core_clk(core_clk), .arst_n(arst_n), .trapCond(trapCond), .flagClear(flagClear),
        .serviceDone(serviceDone), .vectorSegment(vectorSegment), .vectorSpacing(vectorSpacing),
        .nodeReq(nodeReq), .nodeTrapNum(nodeTrapNum), .redirect(redirect), .trapFlags(trapFlags),
        .nodeVector(nodeVector), .intBlock(intBlock), .activePrio(activePrio));
    htvu_pipe_model partner (.core_clk(core_clk), .arst_n(arst_n), .redirect(redirect), .intBlock(intBlock),
        .svcDelay(svcDelay), .serviceDone(serviceDone));
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    // segment on top, trap number scaled by four and by two to the power of the spacing code
    function automatic logic [23:0] vec(input logic [7:0] seg, input logic [6:0] t, input logic [1:0] spc);
        return {seg, 16'(t) << (BASE_SHIFT + spc)};
    endfunction : vec
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expv);
        check_count++;
        if (seen !== expv) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, expv, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic fire(input logic [TRAP_COUNT-1:0] c);
        trapCond = c;
        @(negedge core_clk);
        trapCond = '0;
    endtask : fire
    // bounded wait for a redirect pulse or for the service to end
    task automatic wait_on(input bit idle);
        int n;
        n = 0;
        while ((idle ? intBlock !== 1'b0 : redirect.valid !== 1'b1) && n < 300) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 300) begin
            check("wait", 32'd1, 32'd0);
            close_out();
        end
    endtask : wait_on
    initial begin
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        @(negedge core_clk);
        for (int i = 0; i < TRAP_COUNT; i++) begin
            rnd = lfsr(rnd);
            vectorSegment = (i == FLAG_STACK_UNDERFLOW_FLAG) ? SEG_RESET : rnd[7:0];
            vectorSpacing = (i < CLASS_A_COUNT) ? SPC_DEFAULT : rnd[9:8];
            tn = (i < CLASS_A_COUNT) ? TNUM_SR0 + 7'(2 * i) : TNUM_CLASS_B;
            fire(TRAP_COUNT'(1) << i);
            check("valid", redirect.valid, 1'b1);
            check("trapNum", redirect.trapNum, tn);
            check("addr", redirect.addr, vec(vectorSegment, tn, vectorSpacing));
            check("flags", trapFlags, TRAP_COUNT'(1) << i);
            check("block", intBlock, 1'b1);
            check("prio", activePrio, (i < CLASS_A_COUNT) ? PRIO_A : PRIO_B);
            wait_on(1'b1);
            flagClear = '1;
            @(negedge core_clk);
            flagClear = '0;
            check("cleared", trapFlags, FLAGS_RESET);
        end
        // back-to-back node lookups, fixed corners first
        nodeReq = 1'b1;
        for (int k = 0; k < 12; k++) begin
            rnd = lfsr(rnd);
            nodeTrapNum = (k == 0) ? 7'h5F : (k == 1) ? 7'h6F : (k == 2) ? 7'h62 : rnd[6:0];
            vectorSpacing = (k < 3) ? SPC_DEFAULT : rnd[9:8];
            vectorSegment = rnd[17:10];
            @(negedge core_clk);
            check("nodeVector", nodeVector, vec(vectorSegment, nodeTrapNum, vectorSpacing));
        end
        nodeReq = 1'b0;
        // class B waits behind class A, then class A preempts merged class B
        svcDelay = 8'h14;
        fire(TRAP_COUNT'(1) << FLAG_SR0);
        @(negedge core_clk);
        fire(TRAP_COUNT'(1) << FLAG_UNDEFINED_OPCODE_FLAG);
        check("held", redirect.valid, 1'b0);
        check("both", trapFlags, (TRAP_COUNT'(1) << FLAG_SR0) | (TRAP_COUNT'(1) << FLAG_UNDEFINED_OPCODE_FLAG));
        wait_on(1'b0);
        check("late", redirect.trapNum, TNUM_CLASS_B);
        wait_on(1'b1);
        fire((TRAP_COUNT'(1) << FLAG_SR1) | (TRAP_COUNT'(1) << FLAG_MEMORY_ACCESS_ERROR_FLAG));
        check("merged", redirect.trapNum, TNUM_CLASS_B);
        @(negedge core_clk);
        fire(TRAP_COUNT'(1) << FLAG_STACK_UNDERFLOW_FLAG);
        check("preempt", redirect.trapNum, TNUM_STACK_UNDERFLOW_FLAG);
        check("prioA", activePrio, PRIO_A);
        wait_on(1'b1);
        close_out();
    end
endmodule : testbench
`default_nettype wire
